// file: cadp_pkg.sv
// Shared constants and types for the channel activity and event pin block
package cadp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_EVENT = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_STATE = 8'h0c;
    localparam logic [7:0] OFF_MAP_FIRST = 8'h10;
    localparam logic [7:0] OFF_MAP_SECOND = 8'h14;
    localparam logic [7:0] OFF_SF = 8'h18;
    localparam logic [7:0] OFF_TIMEOUT = 8'h1c;

    // Event flag positions
    localparam int EV_W = 9;
    localparam int EV_RX_DONE = 0;
    localparam int EV_RX_TMO = 1;
    localparam int EV_HOP = 2;
    localparam int EV_DET_DONE = 3;
    localparam int EV_ACT = 4;
    localparam int EV_SETTLED = 5;
    localparam int EV_TX_DONE = 6;
    localparam int EV_HDR = 7;
    localparam int EV_CRC = 8;
    // Extra mux sources above the event flags
    localparam int SRC_LOCK = 9;
    localparam int SRC_CLK = 10;
    localparam int SRC_W = 11;

    // Modem state bit positions
    localparam int MS_DETECTED = 0;
    localparam int MS_SYNCED = 1;
    localparam int MS_HEADER = 3;

    // Mode commands written to the mode register
    localparam logic [1:0] CMD_STANDBY = 2'h0;
    localparam logic [1:0] CMD_CAD = 2'h1;
    localparam logic [1:0] CMD_RX_SINGLE = 2'h2;
    localparam logic [1:0] CMD_RX_CONT = 2'h3;

    // Pin mapping codes
    localparam logic [1:0] MAP_SET0 = 2'h0;
    localparam logic [1:0] MAP_SET1 = 2'h1;
    localparam logic [1:0] MAP_SET2 = 2'h2;
    localparam logic [1:0] MAP_NONE = 2'h3;

    // Reset values and spreading factor limits
    localparam logic [7:0] MAP_FIRST_RST = 8'h00;
    localparam logic [3:0] MAP_SECOND_RST = 4'h0;
    localparam logic [8:0] MASK_RST = 9'h000;
    localparam logic [3:0] SF_RST = 4'h7;
    localparam logic [3:0] SF_MIN = 4'h6;
    localparam logic [3:0] SF_MAX = 4'hc;
    localparam logic [9:0] TIMEOUT_RST = 10'h000;

    // Timing: clock rate, bandwidth, extra capture chips, correlation shortfall
    localparam int CLK_HZ = 40_000_000;
    localparam int BW_HZ_DEF = 125_000;
    localparam int CAD_EXTRA_CHIPS = 32;
    localparam int CORR_SHORT_CHIPS = 16;
    localparam int TMR_W = 26;

    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_LOCK,
        ST_CAPTURE,
        ST_CORR,
        ST_RX_SINGLE,
        ST_RX_CONT
    } cadp_state_t;
endpackage

// file: cadp_chip_timer.sv
// Chip-period down counter with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module cadp_chip_timer #(
    parameter int CHIP_CYCLES = 320,
    parameter int W = cadp_pkg::TMR_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic done
);
    localparam logic [15:0] CHIP_M1 = 16'(CHIP_CYCLES - 1);

    typedef struct packed {
        logic [15:0] pre;
        logic [W-1:0] left;
        logic done;
    } cadp_tmr_t;

    cadp_tmr_t t_q;
    cadp_tmr_t t_d;

    // Start reloads; a zero load aborts; done fires as the last chip ends
    always_comb
    begin
        t_d = t_q;
        t_d.done = 1'b0;
        if (start)
        begin
            t_d.pre = CHIP_M1;
            t_d.left = load;
        end
        else if (t_q.left != '0)
        begin
            if (t_q.pre == 16'h0000)
            begin
                t_d.pre = CHIP_M1;
                t_d.left = t_q.left - W'(1);
                t_d.done = (t_q.left == W'(1));
            end
            else
            begin
                t_d.pre = t_q.pre - 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            t_q <= '0;
        else
            t_q <= t_d;
    end

    assign done = t_q.done;
endmodule
`default_nettype wire

// file: cadp_pin_mux.sv
// Event pin selector driven by two-bit mapping codes
`timescale 1ns/1ps
`default_nettype none
module cadp_pin_mux (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [cadp_pkg::SRC_W-1:0] src,
    input wire logic [7:0] map_first,
    input wire logic [3:0] map_second,
    output logic [5:0] pins
);
    typedef struct packed {
        logic [5:0] pins;
    } cadp_mux_t;

    cadp_mux_t m_q;
    cadp_mux_t m_d;
    logic [11:0] codes;

    // Source of one pin for one mapping code
    function automatic logic pick(input int pin, input logic [1:0] code,
                                  input logic [cadp_pkg::SRC_W-1:0] s);
        logic r;
        r = 1'b0;
        unique case (code)
            cadp_pkg::MAP_SET0:
                unique case (pin)
                    0: r = s[cadp_pkg::EV_RX_DONE];
                    1: r = s[cadp_pkg::EV_RX_TMO];
                    2: r = s[cadp_pkg::EV_HOP];
                    3: r = s[cadp_pkg::EV_DET_DONE];
                    4: r = s[cadp_pkg::EV_ACT];
                    default: r = s[cadp_pkg::EV_SETTLED];
                endcase
            cadp_pkg::MAP_SET1:
                unique case (pin)
                    0: r = s[cadp_pkg::EV_TX_DONE];
                    1, 2: r = s[cadp_pkg::EV_HOP];
                    3: r = s[cadp_pkg::EV_HDR];
                    4: r = s[cadp_pkg::SRC_LOCK];
                    default: r = s[cadp_pkg::SRC_CLK];
                endcase
            cadp_pkg::MAP_SET2:
                unique case (pin)
                    0: r = s[cadp_pkg::EV_DET_DONE];
                    1: r = s[cadp_pkg::EV_ACT];
                    2: r = s[cadp_pkg::EV_HOP];
                    3: r = s[cadp_pkg::EV_CRC];
                    4: r = s[cadp_pkg::SRC_LOCK];
                    default: r = s[cadp_pkg::SRC_CLK];
                endcase
            cadp_pkg::MAP_NONE: r = 1'b0;
        endcase
        return r;
    endfunction

    assign codes = {map_second, map_first};

    // One selector per pin; pins follow the flag level
    always_comb
    begin
        m_d = m_q;
        for (int i = 0; i < 6; i++)
            m_d.pins[i] = pick(i, codes[2*i +: 2], src);
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            m_q <= '0;
        else
            m_q <= m_d;
    end

    assign pins = m_q.pins;
endmodule
`default_nettype wire

// file: cadp_top.sv
// Channel activity detection sequencer, event flags, pin mapping and Wishbone registers
`timescale 1ns/1ps
`default_nettype none
module cadp_top #(
    parameter int BW_HZ = cadp_pkg::BW_HZ_DEF
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic synth_locked,
    input wire logic corr_match,
    input wire logic rx_packet_end,
    input wire logic rx_header_ok,
    input wire logic rx_check_fail,
    input wire logic hop_request,
    input wire logic tx_finished,
    input wire logic preamble_seen,
    input wire logic signal_synced,
    input wire logic clock_output,
    output logic synth_enable,
    output logic rx_enable,
    output logic corr_enable,
    output logic [5:0] event_pin,
    output logic irq
);
    localparam int CHIP_CYCLES = cadp_pkg::CLK_HZ / BW_HZ;
    localparam logic [31:0] CHIP32 = 32'(CHIP_CYCLES);
    localparam int TW = cadp_pkg::TMR_W;

    typedef struct packed {
        cadp_pkg::cadp_state_t st;
        logic [8:0] ev;
        logic [8:0] mask;
        logic [7:0] map1;
        logic [3:0] map2;
        logic [3:0] sf;
        logic [9:0] tmo;
        logic [3:0] mstat;
        logic ack;
        logic [31:0] dat;
        logic synth_en;
        logic rx_en;
        logic corr_en;
        logic irq;
        logic tstart;
        logic [TW-1:0] tload;
    } cadp_regs_t;

    cadp_regs_t r_q;
    cadp_regs_t r_d;
    logic tmr_done;
    logic [5:0] pins;
    logic [31:0] lm;
    logic req;
    logic wr;
    logic [8:0] set;
    logic [8:0] clr;
    logic [1:0] cmd;
    logic cmd_go;
    logic [3:0] sf_w;
    logic [TW-1:0] sym_chips;

    // Address match on word offset
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    // Byte lane enables widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
            m[8*i +: 8] = {8{sel[i]}};
        return m;
    endfunction

    // Bus decode and write helpers
    assign req = wb_cyc && wb_stb && !r_q.ack;
    assign wr = req && wb_we;
    assign lm = lane_mask(wb_sel);
    assign clr = (wr && hit(wb_adr, cadp_pkg::OFF_EVENT)) ? (wb_dat_w[8:0] & lm[8:0]) : 9'h000;
    assign cmd_go = wr && hit(wb_adr, cadp_pkg::OFF_MODE) && wb_sel[0];
    assign cmd = wb_dat_w[1:0];
    assign sf_w = (wb_dat_w[3:0] < cadp_pkg::SF_MIN) ? cadp_pkg::SF_MIN :
                  (wb_dat_w[3:0] > cadp_pkg::SF_MAX) ? cadp_pkg::SF_MAX : wb_dat_w[3:0];
    assign sym_chips = TW'(1) << r_q.sf;

    // Sequencer, event flags, registers and bus answer
    always_comb
    begin
        r_d = r_q;
        r_d.tstart = 1'b0;
        r_d.ack = req;
        set = '0;
        set[cadp_pkg::EV_RX_DONE] = rx_packet_end;
        set[cadp_pkg::EV_HOP] = hop_request;
        set[cadp_pkg::EV_TX_DONE] = tx_finished;
        set[cadp_pkg::EV_HDR] = rx_header_ok;
        set[cadp_pkg::EV_CRC] = rx_check_fail;
        unique case (r_q.st)
            cadp_pkg::ST_STANDBY:
                if (cmd_go && cmd == cadp_pkg::CMD_CAD)
                begin
                    r_d.st = cadp_pkg::ST_LOCK;
                    r_d.synth_en = 1'b1;
                end
                else if (cmd_go && (cmd == cadp_pkg::CMD_RX_SINGLE || cmd == cadp_pkg::CMD_RX_CONT))
                begin
                    r_d.st = (cmd == cadp_pkg::CMD_RX_SINGLE) ? cadp_pkg::ST_RX_SINGLE
                                                              : cadp_pkg::ST_RX_CONT;
                    r_d.synth_en = 1'b1;
                    r_d.rx_en = 1'b1;
                    r_d.mstat[cadp_pkg::MS_HEADER] = 1'b0;
                    r_d.tstart = 1'b1;
                    r_d.tload = TW'(r_q.tmo) << r_q.sf;
                end
            cadp_pkg::ST_LOCK:
                if (synth_locked)
                begin
                    r_d.st = cadp_pkg::ST_CAPTURE;
                    r_d.rx_en = 1'b1;
                    r_d.tstart = 1'b1;
                    r_d.tload = sym_chips + TW'(cadp_pkg::CAD_EXTRA_CHIPS);
                end
            cadp_pkg::ST_CAPTURE:
                if (tmr_done)
                begin
                    r_d.st = cadp_pkg::ST_CORR;
                    r_d.rx_en = 1'b0;
                    r_d.synth_en = 1'b0;
                    r_d.corr_en = 1'b1;
                    r_d.tstart = 1'b1;
                    r_d.tload = sym_chips - TW'(cadp_pkg::CORR_SHORT_CHIPS);
                end
            cadp_pkg::ST_CORR:
                if (tmr_done)
                begin
                    r_d.st = cadp_pkg::ST_STANDBY;
                    r_d.corr_en = 1'b0;
                    set[cadp_pkg::EV_DET_DONE] = 1'b1;
                    set[cadp_pkg::EV_ACT] = corr_match;
                end
            cadp_pkg::ST_RX_SINGLE:
                if (rx_packet_end || tmr_done)
                begin
                    r_d.st = cadp_pkg::ST_STANDBY;
                    r_d.rx_en = 1'b0;
                    r_d.synth_en = 1'b0;
                    set[cadp_pkg::EV_RX_TMO] = tmr_done;
                    // Stop the timer so a stale done cannot hit the next sequence
                    r_d.tstart = 1'b1;
                    r_d.tload = '0;
                end
            cadp_pkg::ST_RX_CONT:
                set[cadp_pkg::EV_RX_TMO] = tmr_done;
        endcase
        // Stand-by command aborts any sequence and stops the timer
        if (cmd_go && cmd == cadp_pkg::CMD_STANDBY && r_q.st != cadp_pkg::ST_STANDBY)
        begin
            r_d.st = cadp_pkg::ST_STANDBY;
            r_d.synth_en = 1'b0;
            r_d.rx_en = 1'b0;
            r_d.corr_en = 1'b0;
            r_d.tstart = 1'b1;
            r_d.tload = '0;
        end
        set[cadp_pkg::EV_SETTLED] = (r_d.st != r_q.st) && (r_d.st != cadp_pkg::ST_LOCK)
                                    && (r_d.st != cadp_pkg::ST_CORR);
        // Hardware set wins over a write-one clear in the same cycle
        r_d.ev = (r_q.ev & ~clr) | set;
        // Modem state bits
        r_d.mstat[cadp_pkg::MS_DETECTED] = preamble_seen;
        r_d.mstat[cadp_pkg::MS_SYNCED] = signal_synced;
        r_d.mstat[2] = 1'b0;
        if (rx_header_ok)
            r_d.mstat[cadp_pkg::MS_HEADER] = 1'b1;
        // Register writes
        if (wr && hit(wb_adr, cadp_pkg::OFF_MASK))
            r_d.mask = (r_q.mask & ~lm[8:0]) | (wb_dat_w[8:0] & lm[8:0]);
        if (wr && hit(wb_adr, cadp_pkg::OFF_MAP_FIRST) && wb_sel[0])
            r_d.map1 = wb_dat_w[7:0];
        if (wr && hit(wb_adr, cadp_pkg::OFF_MAP_SECOND) && wb_sel[0])
            r_d.map2 = wb_dat_w[3:0];
        if (wr && hit(wb_adr, cadp_pkg::OFF_SF) && wb_sel[0])
            r_d.sf = sf_w;
        if (wr && hit(wb_adr, cadp_pkg::OFF_TIMEOUT))
            r_d.tmo = (r_q.tmo & ~lm[9:0]) | (wb_dat_w[9:0] & lm[9:0]);
        r_d.irq = |(r_d.ev & r_d.mask);
        // Read data; unmapped offsets read zero
        r_d.dat = '0;
        if (req && !wb_we)
        begin
            if (hit(wb_adr, cadp_pkg::OFF_MODE))
                r_d.dat[1:0] = (r_q.st == cadp_pkg::ST_STANDBY) ? cadp_pkg::CMD_STANDBY :
                               (r_q.st == cadp_pkg::ST_RX_SINGLE) ? cadp_pkg::CMD_RX_SINGLE :
                               (r_q.st == cadp_pkg::ST_RX_CONT) ? cadp_pkg::CMD_RX_CONT :
                               cadp_pkg::CMD_CAD;
            else if (hit(wb_adr, cadp_pkg::OFF_EVENT))
                r_d.dat[8:0] = r_q.ev;
            else if (hit(wb_adr, cadp_pkg::OFF_MASK))
                r_d.dat[8:0] = r_q.mask;
            else if (hit(wb_adr, cadp_pkg::OFF_STATE))
                r_d.dat[3:0] = r_q.mstat;
            else if (hit(wb_adr, cadp_pkg::OFF_MAP_FIRST))
                r_d.dat[7:0] = r_q.map1;
            else if (hit(wb_adr, cadp_pkg::OFF_MAP_SECOND))
                r_d.dat[3:0] = r_q.map2;
            else if (hit(wb_adr, cadp_pkg::OFF_SF))
                r_d.dat[3:0] = r_q.sf;
            else if (hit(wb_adr, cadp_pkg::OFF_TIMEOUT))
                r_d.dat[9:0] = r_q.tmo;
        end
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            r_q <= '0;
            r_q.sf <= cadp_pkg::SF_RST;
            r_q.mask <= cadp_pkg::MASK_RST;
            r_q.map1 <= cadp_pkg::MAP_FIRST_RST;
            r_q.map2 <= cadp_pkg::MAP_SECOND_RST;
            r_q.tmo <= cadp_pkg::TIMEOUT_RST;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // Phase timer shared by capture, correlation and receive timeout
    cadp_chip_timer #(
        .CHIP_CYCLES(CHIP_CYCLES),
        .W(TW)
    ) u_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(r_q.tstart),
        .load(r_q.tload),
        .done(tmr_done)
    );

    // Event pin routing
    cadp_pin_mux u_mux (
        .clk_sys(clk_sys),
        .reset(reset),
        .src({clock_output, synth_locked, r_q.ev}),
        .map_first(r_q.map1),
        .map_second(r_q.map2),
        .pins(pins)
    );

    // Outputs
    assign wb_dat_r = r_q.dat;
    assign wb_ack = r_q.ack;
    assign synth_enable = r_q.synth_en;
    assign rx_enable = r_q.rx_en;
    assign corr_enable = r_q.corr_en;
    assign event_pin = pins;
    assign irq = r_q.irq;

    // Capture length counter, read only by checks
    logic [31:0] cap_cnt_q;
    logic [31:0] cap_exp;
    always_ff @(posedge clk_sys)
    begin
        if (reset || r_q.st != cadp_pkg::ST_CAPTURE)
            cap_cnt_q <= '0;
        else
            cap_cnt_q <= cap_cnt_q + 32'h1;
    end
    assign cap_exp = ((32'h1 << r_q.sf) + 32'(cadp_pkg::CAD_EXTRA_CHIPS)) * CHIP32 + 32'h1;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Checks
    lock_first_a: assert property ($rose(r_q.st == cadp_pkg::ST_CAPTURE) |->
        $past(synth_locked) && rx_enable && synth_enable)
        else $error("capture started without lock");
    capture_off_a: assert property (r_q.st == cadp_pkg::ST_CORR |->
        !rx_enable && !synth_enable && corr_enable)
        else $error("radio on during correlation");
    rx_window_a: assert property ((r_q.st == cadp_pkg::ST_CAPTURE &&
        r_d.st == cadp_pkg::ST_CORR) |-> cap_cnt_q == cap_exp)
        else $error("capture window length wrong");
    corr_short_a: assert property ($rose(r_q.st == cadp_pkg::ST_CORR) |->
        (r_q.st == cadp_pkg::ST_CORR) [*8])
        else $error("correlation ended too early");
    events_together_a: assert property ((r_q.st == cadp_pkg::ST_CORR && tmr_done &&
        corr_match) |=> r_q.ev[cadp_pkg::EV_DET_DONE] && r_q.ev[cadp_pkg::EV_ACT])
        else $error("detect events not raised together");
    back_standby_a: assert property ((r_q.st == cadp_pkg::ST_CORR && tmr_done) |=>
        r_q.st == cadp_pkg::ST_STANDBY && !corr_enable)
        else $error("no return to stand-by");
    pin_follow_a: assert property (r_q.map1[1:0] == cadp_pkg::MAP_SET0 |=>
        event_pin[0] == $past(r_q.ev[cadp_pkg::EV_RX_DONE]))
        else $error("pin 0 not following receive flag");
    pin_none_a: assert property (r_q.map2[3:2] == cadp_pkg::MAP_NONE |=>
        !event_pin[5])
        else $error("unmapped pin driven high");
    state_bits_a: assert property (preamble_seen && signal_synced |=>
        r_q.mstat[cadp_pkg::MS_DETECTED] && r_q.mstat[cadp_pkg::MS_SYNCED])
        else $error("state bits not tracking modem");
    header_bit_a: assert property (rx_header_ok |=> r_q.mstat[cadp_pkg::MS_HEADER] &&
        r_q.ev[cadp_pkg::EV_HDR])
        else $error("header indication missing");
    timeout_stay_a: assert property ((r_q.st == cadp_pkg::ST_RX_CONT && tmr_done &&
        !cmd_go) |=> r_q.ev[cadp_pkg::EV_RX_TMO] && r_q.st == cadp_pkg::ST_RX_CONT)
        else $error("continuous receive left on timeout");
    set_wins_a: assert property (hop_request |=> r_q.ev[cadp_pkg::EV_HOP])
        else $error("event lost against clear");
    ack_pulse_a: assert property (wb_ack |=> !wb_ack)
        else $error("ack held for two cycles");

    // Main scenarios
    cad_found_c: cover property (r_q.st == cadp_pkg::ST_CORR && tmr_done && corr_match);
    rx_timeout_c: cover property (r_q.st == cadp_pkg::ST_RX_SINGLE && tmr_done);
    irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// file: cadp_radio_model.sv
// Radio chain stand-in: synthesizer lock and correlator result
`timescale 1ns/1ps
`default_nettype none
module cadp_radio_model #(
    parameter int LOCK_DLY = 5
) (
    input wire logic clk_sys,
    input wire logic synth_enable,
    input wire logic corr_enable,
    input wire logic match_want,
    output logic synth_locked,
    output logic corr_match
);
    int cnt = 0;
    logic lock_q = 1'b0;
    // Lock after a settling delay, lost as soon as the synthesizer is off
    always @(posedge clk_sys)
    begin
        cnt <= synth_enable ? cnt + 1 : 0;
        lock_q <= synth_enable && cnt >= LOCK_DLY;
    end
    assign synth_locked = lock_q;
    // Result only means something while correlating; wrong value otherwise
    assign corr_match = corr_enable ? match_want : ~match_want;
endmodule
`default_nettype wire

// file: cadp_top_tb_top.sv
// Self-checking bench for the activity detection and event pin block
`timescale 1ns/1ps
`default_nettype none
module cadp_top_tb_top;
    localparam int CC = 4; // Chip length in clocks at the bench bandwidth
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0, wb_dat_r, rd;
    logic wb_ack, synth_locked, corr_match, synth_enable, rx_enable, corr_enable, irq;
    logic match_want = 1'b0, rx_header_ok = 1'b0, preamble_seen = 1'b0;
    logic signal_synced = 1'b0, clock_output = 1'b0;
    logic [3:0] ev_in = 4'h0; // Pulses: packet end, check fail, hop, transmit done
    logic [5:0] event_pin;
    int miscompares = 0, num_checks = 0;
    cadp_top #(.BW_HZ(10_000_000)) cadp_top_i (.clk_sys(clk_sys), .reset(reset),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .synth_locked(synth_locked), .corr_match(corr_match), .rx_packet_end(ev_in[0]),
        .rx_header_ok(rx_header_ok), .rx_check_fail(ev_in[1]), .hop_request(ev_in[2]),
        .tx_finished(ev_in[3]), .preamble_seen(preamble_seen),
        .signal_synced(signal_synced), .clock_output(clock_output),
        .synth_enable(synth_enable), .rx_enable(rx_enable), .corr_enable(corr_enable),
        .event_pin(event_pin), .irq(irq));
    cadp_radio_model cadp_radio_model_i (.clk_sys(clk_sys), .synth_enable(synth_enable),
        .corr_enable(corr_enable), .match_want(match_want), .synth_locked(synth_locked),
        .corr_match(corr_match));
    // Clock at 40 MHz
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fail_to();
        miscompares++;
        $display("[ERR] %0t wait ran out", $time);
        end_of_test();
    endtask
    // One classic cycle held until acknowledge; read data lands in rd
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat_w <= d;
        for (k = 0; k == 0 || wb_ack !== 1'b1; k++)
        begin
            if (k == 20)
                fail_to();
            @(posedge clk_sys);
        end
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    function automatic logic sig(input int w);
        return w == 0 ? rx_enable : w == 1 ? corr_enable : irq;
    endfunction
    // Wait for a status line to rise, counting cycles spent waiting
    task automatic wait_up(input int w, input int lim, output int len);
        for (len = 0; sig(w) !== 1'b1; len++)
        begin
            if (len == lim)
                fail_to();
            @(posedge clk_sys);
        end
    endtask
    // Measure how many cycles a status line stays up
    task automatic span(input int w, input int lim, output int len);
        wait_up(w, lim, len);
        for (len = 0; sig(w) === 1'b1; len++)
        begin
            if (len == lim)
                fail_to();
            @(posedge clk_sys);
        end
    endtask
    // Reset values, clamping and an unmapped offset
    task automatic regs_case();
        wb(0, cadp_pkg::OFF_SF, 0);
        chk(rd, 32'h7);
        wb(0, cadp_pkg::OFF_MASK, 0);
        chk(rd, 32'h0);
        wb(0, 8'h20, 0);
        chk(rd, 32'h0);
        wb(1, cadp_pkg::OFF_SF, 32'h3);
        wb(0, cadp_pkg::OFF_SF, 0);
        chk(rd, 32'h6);
    endtask
    // One detection pass at the shortest spreading factor
    task automatic cad_run(input logic m, input logic [31:0] exp_ev);
        int len;
        match_want <= m;
        wb(1, cadp_pkg::OFF_EVENT, 32'h1ff);
        wb(1, cadp_pkg::OFF_MODE, {30'h0, cadp_pkg::CMD_CAD});
        @(posedge clk_sys);
        chk(synth_enable, 1'b1);
        span(0, 2000, len);
        chk(len, (2 ** 6 + 32) * CC + 2);
        chk(synth_enable, 1'b0);
        span(1, 2000, len);
        chk(len, (2 ** 6 - 16) * CC + 2);
        wait_up(2, 4, len);
        wb(0, cadp_pkg::OFF_EVENT, 0);
        chk(rd, exp_ev);
        wb(0, cadp_pkg::OFF_MODE, 0);
        chk(rd, {30'h0, cadp_pkg::CMD_STANDBY});
    endtask
    task automatic pin_case(input logic [7:0] f, input logic [3:0] s, input logic [5:0] e);
        wb(1, cadp_pkg::OFF_MAP_FIRST, {24'h0, f});
        wb(1, cadp_pkg::OFF_MAP_SECOND, {28'h0, s});
        repeat (3) @(posedge clk_sys);
        chk(event_pin, e);
    endtask
    // Event inputs onto pins, then a clear that meets a new hop event
    task automatic ev_case();
        ev_in <= 4'hf;
        @(posedge clk_sys);
        ev_in <= 4'h0;
        pin_case(8'h00, 4'h0, 6'h05);
        pin_case(8'h55, 4'h5, 6'h27);
        pin_case(8'haa, 4'ha, 6'h2c);
        chk(irq, 1'b1);
        fork
            wb(1, cadp_pkg::OFF_EVENT, 32'h4);
            begin
                @(posedge clk_sys);
                ev_in <= 4'h4;
                @(posedge clk_sys);
                ev_in <= 4'h0;
            end
        join
        wb(0, cadp_pkg::OFF_EVENT, 0);
        chk(rd, 32'h145);
        wb(1, cadp_pkg::OFF_EVENT, 32'h1ff);
        wb(0, cadp_pkg::OFF_EVENT, 0);
        chk(rd, 32'h0);
    endtask
    // Receive timeout in both receive modes, one symbol long
    task automatic rx_case(input logic [1:0] md, input logic [1:0] after);
        int len;
        wb(1, cadp_pkg::OFF_TIMEOUT, 32'h1);
        wb(1, cadp_pkg::OFF_MASK, 32'h2);
        wb(1, cadp_pkg::OFF_EVENT, 32'h1ff);
        wb(1, cadp_pkg::OFF_MODE, {30'h0, md});
        wait_up(2, 400, len);
        chk(len >= 2 ** 6 * CC - 6 && len <= 2 ** 6 * CC + 6, 1'b1);
        wb(0, cadp_pkg::OFF_MODE, 0);
        chk(rd, {30'h0, after});
        wb(1, cadp_pkg::OFF_EVENT, 32'h2);
        @(posedge clk_sys);
        chk(irq, 1'b0);
        wb(1, cadp_pkg::OFF_MODE, 0);
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        regs_case();
        wb(1, cadp_pkg::OFF_MASK, 32'h1ff);
        cad_run(1'b1, 32'h38);
        pin_case(8'h00, 4'h0, 6'h38);
        clock_output <= 1'b1;
        pin_case(8'haa, 4'ha, 6'h23);
        pin_case(8'h55, 4'h5, 6'h20);
        pin_case(8'hff, 4'hf, 6'h00);
        pin_case(8'h3e, 4'hc, 6'h19);
        wb(1, cadp_pkg::OFF_EVENT, 32'h1ff);
        pin_case(8'h00, 4'h0, 6'h00);
        chk(irq, 1'b0);
        ev_case();
        cad_run(1'b0, 32'h28);
        rx_case(cadp_pkg::CMD_RX_CONT, cadp_pkg::CMD_RX_CONT);
        rx_case(cadp_pkg::CMD_RX_SINGLE, cadp_pkg::CMD_STANDBY);
        preamble_seen <= 1'b1;
        signal_synced <= 1'b1;
        rx_header_ok <= 1'b1;
        @(posedge clk_sys);
        rx_header_ok <= 1'b0;
        wb(0, cadp_pkg::OFF_STATE, 0);
        chk(rd, 32'hb);
        end_of_test();
    end
endmodule
`default_nettype wire
